// File: table_memory_model.sv
// data memory and label area behind the engine, one cycle read latency
`timescale 1ns/1ps
module table_memory_model (
  input wire logic        sys_clk,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_re,
  input wire logic        mem_we,
  output logic     [15:0] mem_rdata,
  input wire logic [15:0] lbl_sel,
  input wire logic [15:0] lbl_addr,
  input wire logic        lbl_re,
  input wire logic        lbl_we,
  output logic     [15:0] lbl_rdata,
  input wire logic [15:0] wr_data
);
  logic [15:0] vmem [0:16383]; // valid data memory
  logic [15:0] lbl  [0:4095];  // label areas, sel in top nibble
  initial mem_rdata = 16'h0000;
  initial lbl_rdata = 16'h0000;
  // data memory; read data toggles when not read so stale use shows
  always @(posedge sys_clk)
  begin
    if (mem_re) mem_rdata <= vmem[mem_addr[13:0]];
    else mem_rdata <= ~mem_rdata;
    if (mem_we) vmem[mem_addr[13:0]] <= wr_data;
  end
  // label area; stray offsets give whatever lies there
  always @(posedge sys_clk)
  begin
    if (lbl_re) lbl_rdata <= lbl[{lbl_sel[3:0], lbl_addr[7:0]}];
    else lbl_rdata <= ~lbl_rdata;
    if (lbl_we) lbl[{lbl_sel[3:0], lbl_addr[7:0]}] <= wr_data;
  end
endmodule : table_memory_model

// File: table_memory_op_engine.sv
// table memory operation engine: copy, bit set/clear and fill
`timescale 1ns/1ps

// How it works
// - copy word count from stack level two
// - one offset shifts both label source and destination
// - copy writes start at the instruction's destination plus the offset
// - each load shifts accumulator down the stack
// - copy pointer error raises the table error flag
// - copy offset checked only as operand plus offset; stray label data copied
// - bit set drives one addressed bit high
// - bit clear drives one addressed bit low
// - bit reference is an octal index
// - word is reference over sixteen, bit remainder
// - reference past table sets flag, no write
// - fill writes one value into every word
// - fill count level one, start in accumulator
// - fill outside valid memory sets the flag
// - hex location counts accepted up to FFF for copy, up to FF for bit and fill
module table_memory_op_engine
  import table_op_pkg::*;
#(
  parameter logic [WORD_W-1:0] VMEM_LAST = VMEM_LAST_DEF // last valid address
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // accumulator loads from the ladder program
  input  wire logic                    acc_load,
  input  wire logic [ACC_W-1:0]        acc_load_value,
  input  wire logic                    label_source_load,
  input  wire logic                    octal_address_load,
  // operation request
  input  wire logic                    op_start,
  input  wire table_op_pkg::op_kind_t  op_kind,
  input  wire logic [WORD_W-1:0]       op_operand,
  input  wire logic                    op_fill_from_mem,
  input  wire logic                    scan_end,
  // data memory port
  output logic [WORD_W-1:0]            mem_addr,
  output logic                         mem_re,
  output logic                         mem_we,
  input  wire logic [WORD_W-1:0]       mem_rdata,
  // label data area port
  output logic [WORD_W-1:0]            lbl_sel,
  output logic [WORD_W-1:0]            lbl_addr,
  output logic                         lbl_re,
  output logic                         lbl_we,
  input  wire logic [WORD_W-1:0]       lbl_rdata,
  // shared write data and status
  output logic [WORD_W-1:0]            wr_data,
  output logic                         busy,
  output logic                         op_done,
  output logic                         table_error_flag
);

  // octal digits one per nibble to a binary index; flags bad digits
  function automatic logic [CNT_W:0] oct_to_bin(input logic [WORD_W-1:0] v);
    logic [CNT_W-1:0] acc;
    logic             bad;
    acc = '0;
    bad = 1'b0;
    for (int i = OCT_DIGITS - 1; i >= 0; i--)
    begin
      bad = bad || (v[i*4 +: 4] > OCT_DIGIT_MAX);
      acc = {acc[CNT_W-4:0], v[i*4 +: 3]};
    end
    return {bad, acc};
  endfunction : oct_to_bin

  logic [ACC_W-1:0]  acc_r;          // accumulator
  logic [ACC_W-1:0]  stk1_r;         // first stack level
  logic [ACC_W-1:0]  stk2_r;         // second stack level
  logic              acc_is_label_r; // accumulator holds a label reference
  logic [CNT_W:0]    oct_conv;       // converted octal value
  state_t            state_r;        // engine state
  op_kind_t          kind_r;         // latched operation
  logic [WORD_W-1:0] operand_r;      // latched instruction operand
  logic              fill_mem_r;     // fill value comes from memory
  logic              from_label_r;   // copy direction label -> memory
  logic [CNT_W-1:0]  cnt_r;          // words left to move
  logic [WORD_W-1:0] src_r;          // running source address
  logic [WORD_W-1:0] dst_r;          // running destination address
  logic [BIT_W-1:0]  bitpos_r;       // bit inside the addressed word
  logic [WORD_W-1:0] fill_val_r;     // value written by a fill
  logic              err_set;        // check found a problem this cycle
  logic [CNT_W:0]    ref_bin;        // bit reference in binary
  logic [CNT_W+BIT_W-1:0] tbl_bits;  // table length in bits
  logic [WORD_W:0]   copy_last;      // last data-memory word of a label copy
  logic [WORD_W:0]   tbl_last;       // last word of a bit or fill table
  logic [WORD_W:0]   bit_word;       // word holding the referenced bit
  logic              op_is_bit;      // request is a bit set or bit clear
  assign oct_conv = oct_to_bin(acc_load_value[WORD_W-1:0]);
  // one decode shared by the operand latch and the digit check
  assign op_is_bit = (op_kind == OP_TABLE_BIT_SET)
                  || (op_kind == OP_TABLE_BIT_CLEAR);
  // accumulator stack: every load pushes the old values down one level
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      acc_r          <= ACC_RST;
      stk1_r         <= ACC_RST;
      stk2_r         <= ACC_RST;
      acc_is_label_r <= 1'b0;
    end
    else if (acc_load)
    begin
      stk2_r <= stk1_r;
      stk1_r <= acc_r;
      // octal address loads arrive as digits and are held in binary
      acc_r <= octal_address_load
             ? {{(ACC_W-CNT_W){1'b0}}, oct_conv[CNT_W-1:0]} : acc_load_value;
      // only a label load marks the source as the label area
      acc_is_label_r <= label_source_load;
    end
  end
  // range arithmetic, widened a bit so wrap-around shows as overflow
  always_comb
  begin
    ref_bin   = oct_to_bin(op_operand);
    tbl_bits  = {stk1_r[CNT_W-1:0], {BIT_W{1'b0}}};
    // destination block moved by the shared offset
    copy_last = {1'b0, operand_r} + {1'b0, stk1_r[WORD_W-1:0]}
              + {{(WORD_W-CNT_W+1){1'b0}}, stk2_r[CNT_W-1:0]}
              - {{WORD_W{1'b0}}, 1'b1};
    tbl_last  = {1'b0, acc_r[WORD_W-1:0]}
              + {{(WORD_W-CNT_W+1){1'b0}}, stk1_r[CNT_W-1:0]}
              - {{WORD_W{1'b0}}, 1'b1};
    bit_word  = {1'b0, acc_r[WORD_W-1:0]}
              + {{(WORD_W-CNT_W+BIT_W+1){1'b0}},
                 operand_r[CNT_W-1:BIT_W]};
    err_set   = 1'b0;
    if (state_r == ST_CHECK)
    begin
      case (kind_r)
        OP_LABEL_AREA_COPY:
          // only operand plus offset is checked, the memory side of a label copy; a memory source and the label side are not
          err_set = (stk2_r[ACC_W-1:CNT_W] != '0)
                 || (stk2_r[CNT_W-1:0] != '0
                     && copy_last > {1'b0, VMEM_LAST});
        OP_TABLE_BIT_SET, OP_TABLE_BIT_CLEAR:
          // operand_r holds the binary reference after the latch
          err_set = (stk1_r[ACC_W-1:0] > {20'h0_0000, TABLE_MAX_CNT})
                 || ({{BIT_W{1'b0}}, operand_r[CNT_W-1:0]} >= tbl_bits)
                 || fill_mem_r
                 || bit_word > {1'b0, VMEM_LAST};
        OP_TABLE_FILL:
          err_set = (stk1_r[ACC_W-1:0] > {20'h0_0000, TABLE_MAX_CNT})
                 || (stk1_r[CNT_W-1:0] != '0
                     && tbl_last > {1'b0, VMEM_LAST});
        default:
          err_set = 1'b1;
      endcase
    end
  end
  // operation sequencer and memory strobes
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r      <= ST_IDLE;
      kind_r       <= OP_LABEL_AREA_COPY;
      operand_r    <= WORD_RST;
      fill_mem_r   <= 1'b0;
      from_label_r <= 1'b0;
      cnt_r        <= '0;
      src_r        <= WORD_RST;
      dst_r        <= WORD_RST;
      bitpos_r     <= '0;
      fill_val_r   <= WORD_RST;
      mem_addr     <= WORD_RST;
      mem_re       <= 1'b0;
      mem_we       <= 1'b0;
      lbl_sel      <= WORD_RST;
      lbl_addr     <= WORD_RST;
      lbl_re       <= 1'b0;
      lbl_we       <= 1'b0;
      wr_data      <= WORD_RST;
      busy         <= 1'b0;
      op_done      <= 1'b0;
    end
    else
    begin
      // strobes are single-cycle pulses by default
      mem_re  <= 1'b0;
      mem_we  <= 1'b0;
      lbl_re  <= 1'b0;
      lbl_we  <= 1'b0;
      op_done <= 1'b0;
      case (state_r)
        ST_IDLE:
          // requests while busy are ignored, so only idle latches one
          if (op_start)
          begin
            kind_r     <= op_kind;
            busy       <= 1'b1;
            state_r    <= ST_CHECK;
            // bit ops keep the binary reference; a bad digit forces error
            operand_r  <= op_is_bit
                        ? {{(WORD_W-CNT_W){1'b0}}, ref_bin[CNT_W-1:0]}
                        : op_operand;
            fill_mem_r <= op_is_bit ? ref_bin[CNT_W]
                        : op_fill_from_mem;
          end
        ST_CHECK:
          if (err_set)
            state_r <= ST_DONE;
          else
          begin
            case (kind_r)
              OP_LABEL_AREA_COPY:
              begin
                cnt_r        <= stk2_r[CNT_W-1:0];
                from_label_r <= acc_is_label_r;
                // a label picks the area; a memory source takes the area from the operand
                lbl_sel <= acc_is_label_r ? acc_r[WORD_W-1:0] : operand_r;
                src_r   <= acc_is_label_r ? stk1_r[WORD_W-1:0]
                         : acc_r[WORD_W-1:0] + stk1_r[WORD_W-1:0];
                // destination in memory starts at operand plus offset
                dst_r   <= acc_is_label_r ? operand_r + stk1_r[WORD_W-1:0]
                         : stk1_r[WORD_W-1:0];
                state_r <= (stk2_r[CNT_W-1:0] == '0) ? ST_DONE : ST_COPY_RD;
              end
              OP_TABLE_BIT_SET, OP_TABLE_BIT_CLEAR:
              begin
                dst_r    <= bit_word[WORD_W-1:0];
                bitpos_r <= operand_r[BIT_W-1:0];
                state_r  <= ST_BIT_RD;
              end
              default:
              begin
                cnt_r      <= stk1_r[CNT_W-1:0];
                dst_r      <= acc_r[WORD_W-1:0];
                fill_val_r <= operand_r;
                // an empty table ends at once; a memory value is read first
                state_r    <= (stk1_r[CNT_W-1:0] == '0) ? ST_DONE
                            : fill_mem_r ? ST_FILL_SRC : ST_FILL_WR;
              end
            endcase
          end
        ST_COPY_RD:
        begin
          // read one source word; data returns the cycle after the strobe
          lbl_re <= from_label_r;
          mem_re <= !from_label_r;
          if (from_label_r)
            lbl_addr <= src_r;
          else
            mem_addr <= src_r;
          state_r <= ST_COPY_WAIT;
        end
        ST_COPY_WAIT:
          state_r <= ST_COPY_WR;
        ST_COPY_WR:
        begin
          // stray label words pass through unchecked
          wr_data <= from_label_r ? lbl_rdata : mem_rdata;
          mem_we  <= from_label_r;
          lbl_we  <= !from_label_r;
          if (from_label_r)
            mem_addr <= dst_r;
          else
            lbl_addr <= dst_r;
          src_r   <= src_r + 16'h0001;
          dst_r   <= dst_r + 16'h0001;
          cnt_r   <= cnt_r - 12'h001;
          state_r <= (cnt_r == 12'h001) ? ST_DONE : ST_COPY_RD;
        end
        ST_BIT_RD:
        begin
          mem_addr <= dst_r;
          mem_re   <= 1'b1;
          state_r  <= ST_BIT_WAIT;
        end
        ST_BIT_WAIT:
          state_r <= ST_BIT_WR;
        ST_BIT_WR:
        begin
          // read-modify-write keeps the other fifteen bits
          wr_data           <= mem_rdata;
          wr_data[bitpos_r] <= (kind_r == OP_TABLE_BIT_SET);
          mem_addr <= dst_r;
          mem_we   <= 1'b1;
          state_r  <= ST_DONE;
        end
        ST_FILL_SRC:
        begin
          // the operand names a memory word holding the fill value
          mem_addr <= operand_r;
          mem_re   <= 1'b1;
          state_r  <= ST_FILL_WAIT;
        end
        ST_FILL_WAIT:
          state_r <= ST_FILL_WR;
        ST_FILL_WR:
        begin
          // first write of a memory fill captures the returning word
          wr_data    <= fill_mem_r ? mem_rdata : fill_val_r;
          fill_val_r <= fill_mem_r ? mem_rdata : fill_val_r;
          fill_mem_r <= 1'b0;
          mem_addr <= dst_r;
          mem_we   <= 1'b1;
          dst_r    <= dst_r + 16'h0001;
          cnt_r    <= cnt_r - 12'h001;
          state_r  <= (cnt_r == 12'h001) ? ST_DONE : ST_FILL_WR;
        end
        ST_DONE:
        begin
          busy    <= 1'b0;
          op_done <= 1'b1;
          state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_DONE; // a stray state ends like an operation
      endcase
    end
  end
  // shared error flag: set by a failed check, cleared at start or scan end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      table_error_flag <= 1'b0;
    else if (err_set)
      table_error_flag <= 1'b1;
    else if (state_r == ST_IDLE && op_start)
      table_error_flag <= 1'b0;
    else if (scan_end)
      table_error_flag <= 1'b0;
  end

endmodule : table_memory_op_engine

// File: table_memory_op_engine_asserts.sv
// concurrent checks on the ports of the table memory operation engine
`timescale 1ns/1ps
module table_memory_op_engine_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic op_start,
  input wire logic scan_end,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic lbl_re,
  input wire logic lbl_we,
  input wire logic busy,
  input wire logic op_done,
  input wire logic table_error_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // a request that the idle engine accepts
  sequence s_take; op_start && !busy; endsequence
  // any write, to either memory
  sequence s_write; mem_we || lbl_we; endsequence
  property p_busy; s_take |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy late");
  property p_clear; s_take |=> !table_error_flag; endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  // a refused operation must leave both memories alone
  property p_nowr;
    busy && table_error_flag |-> !(mem_we || lbl_we);
  endproperty
  a_nowr: assert property (p_nowr) else $error("write on error");
  // a new request may be taken in the done cycle, so busy may rise next
  property p_pulse; op_done |-> !busy ##1 !op_done; endproperty
  a_pulse: assert property (p_pulse) else $error("done stuck");
  property p_scan; scan_end && !busy |=> !table_error_flag; endproperty
  a_scan: assert property (p_scan) else $error("scan end kept");
  // flag only moves at a start, a check or a scan end
  property p_hold;
    !busy && !scan_end && !op_start |=> $stable(table_error_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved");
  property p_rdwr; mem_re |-> ##2 s_write; endproperty
  a_rdwr: assert property (p_rdwr) else $error("no write");
  property p_lblwr; lbl_re |-> ##2 mem_we; endproperty
  a_lblwr: assert property (p_lblwr) else $error("no copy");
  // busy drops in the very cycle the done pulse stands
  property p_fell; $fell(busy) |-> op_done; endproperty
  a_fell: assert property (p_fell) else $error("busy fell");
  c_err: cover property (busy && table_error_flag);
endmodule : table_memory_op_engine_asserts

// File: table_memory_op_engine_bench.sv
// self-checking bench for the table memory operation engine
`timescale 1ns/1ps
`define CHK(nm,e,g) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module table_memory_op_engine_bench;
  import table_op_pkg::*;
  logic              sys_clk, rst_n, acc_load, label_source_load;
  logic              octal_address_load, op_start, op_fill_from_mem;
  logic              scan_end;
  logic [ACC_W-1:0]  acc_load_value;
  op_kind_t          op_kind;
  logic [WORD_W-1:0] op_operand;
  logic [15:0]       mem_addr, mem_rdata, lbl_sel, lbl_addr, lbl_rdata;
  logic [15:0]       wr_data;
  logic              mem_re, mem_we, lbl_re, lbl_we, busy, op_done;
  logic              table_error_flag;
  int                bad_count, num_checks, cyc;
  table_memory_op_engine dut (.sys_clk, .rst_n, .acc_load,
    .acc_load_value, .label_source_load, .octal_address_load, .op_start,
    .op_kind, .op_operand, .op_fill_from_mem, .scan_end, .mem_addr,
    .mem_re, .mem_we, .mem_rdata, .lbl_sel, .lbl_addr, .lbl_re, .lbl_we,
    .lbl_rdata, .wr_data, .busy, .op_done, .table_error_flag);
  table_memory_model mdl (.sys_clk, .mem_addr, .mem_re, .mem_we,
    .mem_rdata, .lbl_sel, .lbl_addr, .lbl_re, .lbl_we, .lbl_rdata,
    .wr_data);
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // one accumulator push, a cycle apart from the next
  task ld(input logic [31:0] v, input logic l, input logic o);
    @(negedge sys_clk);
    acc_load = 1; acc_load_value = v;
    label_source_load = l; octal_address_load = o;
    @(negedge sys_clk);
    acc_load = 0; label_source_load = 0; octal_address_load = 0;
  endtask : ld
  // issue one operation and wait for its done pulse
  task run(input op_kind_t k, input logic [15:0] opd, input logic fm);
    int n;
    @(negedge sys_clk);
    op_start = 1; op_kind = k; op_operand = opd; op_fill_from_mem = fm;
    @(negedge sys_clk);
    op_start = 0;
    n = 0;
    while (op_done !== 1'b1 && n < 600)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("op_done", 1'b1, op_done)
    @(negedge sys_clk);
  endtask : run
  task t_copy;
    for (int i = 0; i < 6; i++)
    begin
      mdl.lbl[{4'h5, 8'(i)}] = 16'hA000 + 16'(i);
      mdl.vmem[14'h100 + i] = 16'h0000;
      mdl.vmem[14'h200 + i] = 16'hC000 + 16'(i);
      mdl.lbl[{4'h7, 8'(i)}] = 16'h0000;
    end
    ld(4, 0, 0); ld(1, 0, 0); ld(5, 1, 0);
    run(OP_LABEL_AREA_COPY, 16'h0100, 0);
    for (int i = 0; i < 4; i++)
      `CHK("cp", 16'hA001 + 16'(i), mdl.vmem[14'h101 + i])
    `CHK("cp lo", 16'h0000, mdl.vmem[14'h100])
    `CHK("cp hi", 16'h0000, mdl.vmem[14'h105])
    ld(2, 0, 0); ld(1, 0, 0); ld(32'h200, 0, 0);
    run(OP_LABEL_AREA_COPY, 16'h0007, 0);
    `CHK("cpm0", 16'hC001, mdl.lbl[{4'h7, 8'h01}])
    `CHK("cpm1", 16'hC002, mdl.lbl[{4'h7, 8'h02}])
    `CHK("cpm2", 16'h0000, mdl.lbl[{4'h7, 8'h03}])
    `CHK("cp flag", 1'b0, table_error_flag)
    ld(32'h1001, 0, 0); ld(0, 0, 0); ld(5, 1, 0);
    run(OP_LABEL_AREA_COPY, 16'h0100, 0);
    `CHK("cp err", 1'b1, table_error_flag)
    `CHK("cp nowr", 16'h0000, mdl.vmem[14'h100])
    $display("copy tests done");
  endtask : t_copy
  // two-word table at octal 3000, loaded through the octal path
  task t_bit(input op_kind_t k, input logic [15:0] rf, v0, v1, e0, e1,
             input logic ef);
    mdl.vmem[14'h600] = v0;
    mdl.vmem[14'h601] = v1;
    ld(2, 0, 0); ld(32'h3000, 0, 1);
    run(k, rf, 0);
    `CHK("bit w0", e0, mdl.vmem[14'h600])
    `CHK("bit w1", e1, mdl.vmem[14'h601])
    `CHK("bit flag", ef, table_error_flag)
  endtask : t_bit
  task t_bits;
    t_bit(OP_TABLE_BIT_SET, 16'h0034, 0, 0, 0, 16'h1000, 0);
    t_bit(OP_TABLE_BIT_CLEAR, 16'h0034, 16'hFFFF, 16'hFFFF, 16'hFFFF,
          16'hEFFF, 0);
    t_bit(OP_TABLE_BIT_CLEAR, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFE,
          16'hFFFF, 0);
    t_bit(OP_TABLE_BIT_SET, 16'h0040, 0, 0, 0, 0, 1);
    t_bit(OP_TABLE_BIT_SET, 16'h0037, 0, 0, 0, 16'h8000, 0);
    t_bit(OP_TABLE_BIT_SET, 16'h0008, 0, 0, 0, 0, 1);
    t_bit(OP_TABLE_BIT_SET, 16'h0040, 0, 0, 0, 0, 1);
    @(negedge sys_clk);
    scan_end = 1;
    @(negedge sys_clk);
    scan_end = 0;
    `CHK("scan clr", 1'b0, table_error_flag)
    $display("bit tests done");
  endtask : t_bits
  task t_fill;
    mdl.vmem[14'h703] = 16'h0000;
    mdl.vmem[14'h710] = 16'h1234;
    mdl.vmem[14'h8FF] = 16'h0000;
    mdl.vmem[14'h3FFE] = 16'h0000;
    ld(3, 0, 0); ld(32'h700, 0, 0);
    run(OP_TABLE_FILL, 16'hBEEF, 0);
    for (int i = 0; i < 3; i++)
      `CHK("fill", 16'hBEEF, mdl.vmem[14'h700 + i])
    `CHK("fill end", 16'h0000, mdl.vmem[14'h703])
    ld(2, 0, 0); ld(32'h720, 0, 0);
    run(OP_TABLE_FILL, 16'h0710, 1);
    `CHK("fill mem", 16'h1234, mdl.vmem[14'h721])
    ld(32'hFF, 0, 0); ld(32'h800, 0, 0);
    run(OP_TABLE_FILL, 16'h5A5A, 0);
    `CHK("fill ff", 16'h5A5A, mdl.vmem[14'h8FE])
    `CHK("fill ff+1", 16'h0000, mdl.vmem[14'h8FF])
    ld(3, 0, 0); ld(32'h3FFE, 0, 0);
    run(OP_TABLE_FILL, 16'h1111, 0);
    `CHK("fill err", 1'b1, table_error_flag)
    `CHK("fill nowr", 16'h0000, mdl.vmem[14'h3FFE])
    $display("fill tests done");
  endtask : t_fill
  initial
  begin
    rst_n = 0; acc_load = 0; label_source_load = 0;
    octal_address_load = 0; op_start = 0; op_fill_from_mem = 0;
    scan_end = 0; acc_load_value = 0; op_kind = OP_LABEL_AREA_COPY;
    op_operand = 0; bad_count = 0; num_checks = 0; cyc = 0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1;
    t_copy();
    t_bits();
    t_fill();
    summarize();
  end
endmodule : table_memory_op_engine_bench
bind table_memory_op_engine table_memory_op_engine_asserts chk (.sys_clk,
  .rst_n, .op_start, .scan_end, .mem_re, .mem_we, .lbl_re, .lbl_we,
  .busy, .op_done, .table_error_flag);

// File: table_op_pkg.sv
// shared constants and types for the table memory operation engine
package table_op_pkg;

  // widths of the datapath
  localparam int unsigned WORD_W  = 16;   // one data-memory word
  localparam int unsigned ACC_W   = 32;   // accumulator and stack levels
  localparam int unsigned CNT_W   = 12;   // hex word count, up to FFF
  localparam int unsigned BIT_W   = 4;    // bit position inside a word

  // count limits
  localparam logic [CNT_W-1:0] COPY_MAX_CNT  = 12'hFFF;
  localparam logic [CNT_W-1:0] TABLE_MAX_CNT = 12'h0FF;

  // bit reference: four octal digits carried one to a nibble
  localparam int unsigned OCT_DIGITS = 4;
  localparam logic [3:0]  OCT_DIGIT_MAX = 4'h7;

  // default last valid data-memory address
  localparam logic [WORD_W-1:0] VMEM_LAST_DEF = 16'h3FFF;

  // reset values
  localparam logic [ACC_W-1:0]  ACC_RST  = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // operations that the scanning processor can issue
  typedef enum logic [1:0] {
    OP_LABEL_AREA_COPY,
    OP_TABLE_BIT_SET,
    OP_TABLE_BIT_CLEAR,
    OP_TABLE_FILL
  } op_kind_t;

  // engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CHECK,
    ST_COPY_RD,
    ST_COPY_WAIT,
    ST_COPY_WR,
    ST_BIT_RD,
    ST_BIT_WAIT,
    ST_BIT_WR,
    ST_FILL_SRC,
    ST_FILL_WAIT,
    ST_FILL_WR,
    ST_DONE
  } state_t;

endpackage : table_op_pkg
